// >>> rtl/vsw_defs.svh
// offsets, reset values, field positions and timings of the switch block
// assumes inclusion by bare name
`ifndef VSW_DEFS_SVH
`define VSW_DEFS_SVH

// register offsets
`define VSW_OFS_HS_MODES   8'h00
`define VSW_OFS_AUX_MODES  8'h01
`define VSW_OFS_RX_SET     8'h10
`define VSW_OFS_TERM_SEL   8'h11
`define VSW_OFS_EQ_LEVEL   8'h14
`define VSW_OFS_TX_SET     8'h20
`define VSW_OFS_POLARITY   8'h80
`define VSW_OFS_MAP_A      8'h81
`define VSW_OFS_MAP_B      8'h82

// reset values
`define VSW_RST_HS_MODES   8'h40
`define VSW_RST_AUX_MODES  8'hc0
`define VSW_RST_RX_SET     8'h01
`define VSW_RST_TERM_SEL   8'h00
`define VSW_RST_EQ_LEVEL   8'hff
`define VSW_RST_TX_SET     8'h03
`define VSW_RST_POLARITY   8'h00
`define VSW_RST_MAP_A      8'he4
`define VSW_RST_MAP_B      8'he4

// field positions
`define VSW_BIT_ENABLE     6
`define VSW_BIT_SOURCE     0
`define VSW_BIT_LOCK       7
`define VSW_BIT_TERM_MODE  0
`define VSW_BIT_OUT_TERM   1
`define VSW_BIT_OUT_CUR    0
`define VSW_MSB_EMPH       3
`define VSW_LSB_EMPH       2

// fixed upper six slave address bits
`define VSW_DEV_ADDR_HI    6'h24

// hot plug low time, one cycle past 100 ms
`define VSW_HPD_LOW_MS     100
`define VSW_CLK_KHZ        10000
`define VSW_HPD_LOW_CYC    (`VSW_HPD_LOW_MS * `VSW_CLK_KHZ + 1)

`endif

// >>> rtl/vsw_pkg.sv
// types of the switch block
// assumes vsw_defs.svh is on the include path
package vsw_pkg;
   typedef logic [7:0] vsw_byte_t;
   typedef logic [3:0] vsw_idx_t;

   // serial slave states, one-hot
   typedef enum logic [8:0]
   {
      VSW_IDLE = 9'h001,
      VSW_ADDR = 9'h002,
      VSW_AACK = 9'h004,
      VSW_REGA = 9'h008,
      VSW_RACK = 9'h010,
      VSW_WDAT = 9'h020,
      VSW_WACK = 9'h040,
      VSW_RDAT = 9'h080,
      VSW_DACK = 9'h100
   } vsw_state_e;
endpackage : vsw_pkg

// >>> rtl/vsw_hpd_if.sv
// carrier from register block to hot plug timer
// both ends on one clock
interface vsw_hpd_if;
   logic switch_evt;
   logic hold_low;
   modport ctl (output switch_evt, input hold_low);
   modport tmr (input switch_evt, output hold_low);
endinterface : vsw_hpd_if

// >>> rtl/vsw_hpd_timer.sv
// hot plug low-pulse timer, retriggered by each switch
// assumes switch_evt is a one-cycle pulse on clk_i
`include "vsw_defs.svh"
module vsw_hpd_timer #(
   parameter int unsigned LOW_CYCLES = `VSW_HPD_LOW_CYC
)(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // event in, hold out
   vsw_hpd_if.tmr    hpd
);
   import vsw_pkg::*;

   localparam int unsigned CW = $clog2(LOW_CYCLES + 1);
   logic [CW-1:0] remain;

   // a new switch restarts the low time, so the sink sees one long pulse
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         remain       <= '0;
         hpd.hold_low <= 1'b0;
      end
      else if (hpd.switch_evt)
      begin
         remain       <= CW'(LOW_CYCLES);
         hpd.hold_low <= 1'b1;
      end
      else if (remain != '0)
      begin
         remain       <= remain - CW'(1);
         hpd.hold_low <= (remain != CW'(1));
      end
      else
      begin
         hpd.hold_low <= 1'b0;
      end
   end
endmodule : vsw_hpd_timer

// >>> rtl/vsw_regs_top.sv
// register bank of a two-source video link switch, a two-wire bus slave
// assumes scl, sda and address select are async and far slower than clk_i
//
// Functional notes
// - slave address 100100 plus select pin, msb first
// - select pin high gives address lsb 1, low gives 0
// - read starts with address, write bit, register byte; both acknowledged
// - addressed register shifted out msb first
// - reread without register byte returns the same register
// - every register readable and writable over the bus
// - fast path enable bit: 0 standby, 1 lanes on
// - fast source select: 0 source A lanes, 1 source B lanes
// - lock bit slaves side selection to fast selection
// - side enable bit connects chosen side to common side
// - side source select: 0 source A lines, 1 source B lines
// - termination mode: 0 per-bit manual, 1 all connected
// - manual termination bits map A0..A3 then B3..B0
// - equaliser bits 0 low, 1 high, termination lane order
// - two-bit emphasis field for all output lanes, four levels
// - one bit switches all output terminations
// - one bit selects low or high drive current
// - polarity bits swap lane legs; low nibble source A, high source B
// - source A map: field x picks input lane for output x
// - source B map: field x picks input lane for output x
// - hot plug lines pulled low over 100 ms on each switch
// - write: one data byte after register byte, stored, acked
// - reset low restores all register defaults
`include "vsw_defs.svh"

module vsw_regs_top #(
   parameter int unsigned HPD_LOW_CYCLES = `VSW_HPD_LOW_CYC
)(
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_b_i,
   // two-wire serial bus, open drain
   input  wire logic            scl_i,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe_o,
   input  wire logic            addr_sel_i,
   // hot plug lines, open drain
   output logic                 hot_plug_line_o,
   output logic                 hot_plug_line_oe_o,
   // fast path control
   output logic                 fast_path_enable_o,
   output logic                 fast_source_select_o,
   output logic [3:0]           out_lane_pick_0_o,
   output logic [3:0]           out_lane_pick_1_o,
   output logic [3:0]           out_lane_pick_2_o,
   output logic [3:0]           out_lane_pick_3_o,
   output logic [3:0]           src_a_polarity_o,
   output logic [3:0]           src_b_polarity_o,
   // side path control
   output logic                 side_path_enable_o,
   output logic                 side_source_select_o,
   // analog settings
   output logic [7:0]           input_term_bits_o,
   output logic [7:0]           eq_level_bits_o,
   output logic [1:0]           emphasis_level_o,
   output logic                 output_term_on_o,
   output logic                 output_current_level_o,
   // raw lane maps
   output vsw_pkg::vsw_byte_t   src_a_lane_map_o,
   output vsw_pkg::vsw_byte_t   src_b_lane_map_o
);
   import vsw_pkg::*;

   // ************************************************************
   // register index decode
   // ************************************************************

   localparam vsw_idx_t NONE = 4'hf;

   // bus register address to storage index, NONE if unmapped
   function automatic vsw_idx_t reg_index(input vsw_byte_t a);
      case (a)
         `VSW_OFS_HS_MODES:  reg_index = 4'h0;
         `VSW_OFS_AUX_MODES: reg_index = 4'h1;
         `VSW_OFS_RX_SET:    reg_index = 4'h2;
         `VSW_OFS_TERM_SEL:  reg_index = 4'h3;
         `VSW_OFS_EQ_LEVEL:  reg_index = 4'h4;
         `VSW_OFS_TX_SET:    reg_index = 4'h5;
         `VSW_OFS_POLARITY:  reg_index = 4'h6;
         `VSW_OFS_MAP_A:     reg_index = 4'h7;
         `VSW_OFS_MAP_B:     reg_index = 4'h8;
         default:            reg_index = NONE;
      endcase
   endfunction : reg_index

   // default contents per storage index
   function automatic vsw_byte_t reset_value(input int i);
      case (i)
         0:       reset_value = `VSW_RST_HS_MODES;
         1:       reset_value = `VSW_RST_AUX_MODES;
         2:       reset_value = `VSW_RST_RX_SET;
         3:       reset_value = `VSW_RST_TERM_SEL;
         4:       reset_value = `VSW_RST_EQ_LEVEL;
         5:       reset_value = `VSW_RST_TX_SET;
         6:       reset_value = `VSW_RST_POLARITY;
         7:       reset_value = `VSW_RST_MAP_A;
         default: reset_value = `VSW_RST_MAP_B;
      endcase
   endfunction : reset_value

   // one-hot input lane picked by a two-bit map field
   function automatic logic [3:0] lane_pick(input logic [1:0] f);
      lane_pick = 4'h1 << f;
   endfunction : lane_pick

   // ************************************************************
   // pin synchronisers and bus condition detect
   // ************************************************************

   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [1:0] asel_sync;
   logic       scl_q;
   logic       sda_q;

   // two flops per pin; edges use only stage two and its delayed copy
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         scl_sync  <= 2'h3;
         sda_sync  <= 2'h3;
         asel_sync <= 2'h0;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
      end
      else
      begin
         scl_sync  <= {scl_sync[0], scl_i};
         sda_sync  <= {sda_sync[0], sda_i};
         asel_sync <= {asel_sync[0], addr_sel_i};
         scl_q     <= scl_sync[1];
         sda_q     <= sda_sync[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   // start and stop: sda edges while scl is high
   assign scl_s     = scl_sync[1];
   assign sda_s     = sda_sync[1];
   assign scl_rise  = scl_s & ~scl_q;
   assign scl_fall  = ~scl_s & scl_q;
   assign bus_start = scl_s & scl_q & ~sda_s & sda_q;
   assign bus_stop  = scl_s & scl_q & sda_s & ~sda_q;

   // ************************************************************
   // serial slave
   // ************************************************************

   vsw_state_e state;
   logic [2:0] bit_cnt;
   logic       got_byte;
   vsw_byte_t  shreg;
   vsw_byte_t  tx_byte;
   vsw_byte_t  reg_addr;
   logic       master_ack;
   logic       wr_en;
   vsw_byte_t  wr_data;
   vsw_byte_t  rdata;
   logic       addr_hit;

   vsw_byte_t  cfg [0:8];
   vsw_idx_t   rd_idx;

   // pin followed live: a re-strapped board answers at once
   assign addr_hit = (shreg[7:1] == {`VSW_DEV_ADDR_HI, asel_sync[1]});
   assign rd_idx   = reg_index(reg_addr);
   assign rdata    = (rd_idx == NONE) ? 8'h00 : cfg[rd_idx];

   // sample on scl rise, change sda only on scl fall
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         state      <= VSW_IDLE;
         bit_cnt    <= 3'h0;
         got_byte   <= 1'b0;
         shreg      <= 8'h00;
         tx_byte    <= 8'h00;
         reg_addr   <= 8'h00;
         master_ack <= 1'b0;
         sda_oe_o   <= 1'b0;
         wr_en      <= 1'b0;
         wr_data    <= 8'h00;
      end
      else
      begin
         wr_en <= 1'b0;
         if (bus_start)
         begin
            // repeated start keeps reg_addr for a bare reread
            state    <= VSW_ADDR;
            bit_cnt  <= 3'h0;
            got_byte <= 1'b0;
            sda_oe_o <= 1'b0;
         end
         else if (bus_stop)
         begin
            state    <= VSW_IDLE;
            sda_oe_o <= 1'b0;
         end
         else if (scl_rise)
         begin
            case (state)
               VSW_ADDR, VSW_REGA, VSW_WDAT:
               begin
                  shreg    <= {shreg[6:0], sda_s};
                  bit_cnt  <= bit_cnt + 3'h1;
                  got_byte <= (bit_cnt == 3'h7);
               end
               VSW_RDAT:
               begin
                  bit_cnt  <= bit_cnt + 3'h1;
                  got_byte <= (bit_cnt == 3'h7);
               end
               VSW_DACK:
                  master_ack <= ~sda_s;
               default:
                  bit_cnt <= bit_cnt;
            endcase
         end
         else if (scl_fall)
         begin
            case (state)
               VSW_ADDR:
                  if (got_byte)
                  begin
                     got_byte <= 1'b0;
                     if (addr_hit)
                     begin
                        state    <= VSW_AACK;
                        sda_oe_o <= 1'b1;
                     end
                     else
                        state <= VSW_IDLE;
                  end
               VSW_AACK:
                  if (shreg[0])
                  begin
                     state    <= VSW_RDAT;
                     tx_byte  <= rdata;
                     sda_oe_o <= ~rdata[7];
                     bit_cnt  <= 3'h0;
                  end
                  else
                  begin
                     state    <= VSW_REGA;
                     sda_oe_o <= 1'b0;
                     bit_cnt  <= 3'h0;
                  end
               VSW_REGA:
                  if (got_byte)
                  begin
                     got_byte <= 1'b0;
                     reg_addr <= shreg;
                     state    <= VSW_RACK;
                     sda_oe_o <= 1'b1;
                  end
               VSW_RACK:
               begin
                  state    <= VSW_WDAT;
                  sda_oe_o <= 1'b0;
                  bit_cnt  <= 3'h0;
               end
               VSW_WDAT:
                  if (got_byte)
                  begin
                     got_byte <= 1'b0;
                     wr_en    <= 1'b1;
                     wr_data  <= shreg;
                     state    <= VSW_WACK;
                     sda_oe_o <= 1'b1;
                  end
               VSW_WACK:
               begin
                  // bytes after one write are ignored until a start
                  state    <= VSW_IDLE;
                  sda_oe_o <= 1'b0;
               end
               VSW_RDAT:
                  if (got_byte)
                  begin
                     got_byte <= 1'b0;
                     state    <= VSW_DACK;
                     sda_oe_o <= 1'b0;
                  end
                  else
                  begin
                     tx_byte  <= {tx_byte[6:0], 1'b0};
                     sda_oe_o <= ~tx_byte[6];
                  end
               VSW_DACK:
                  if (master_ack)
                  begin
                     // an acking master gets the same register again
                     state    <= VSW_RDAT;
                     tx_byte  <= rdata;
                     sda_oe_o <= ~rdata[7];
                     bit_cnt  <= 3'h0;
                  end
                  else
                     state <= VSW_IDLE;
               VSW_IDLE:
                  sda_oe_o <= 1'b0;
               default:
               begin
                  state    <= VSW_IDLE;
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // register storage
   // ************************************************************

   vsw_idx_t wr_idx;

   assign wr_idx = reg_index(reg_addr);

   // indexed storage; unmapped writes are dropped
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         for (int i = 0; i < 9; i++)
            cfg[i] <= reset_value(i);
      end
      else if (wr_en && (wr_idx != NONE))
      begin
         cfg[wr_idx] <= wr_data;
      end
   end

   // ************************************************************
   // decoded control outputs
   // ************************************************************

   logic next_side_sel;
   logic next_fast_sel;

   assign next_fast_sel = cfg[0][`VSW_BIT_SOURCE];
   assign next_side_sel = cfg[1][`VSW_BIT_LOCK] ? next_fast_sel : cfg[1][`VSW_BIT_SOURCE];

   // path selection, one cycle behind the write
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         fast_path_enable_o   <= 1'b0;
         fast_source_select_o <= 1'b0;
         side_path_enable_o   <= 1'b0;
         side_source_select_o <= 1'b0;
      end
      else
      begin
         fast_path_enable_o   <= cfg[0][`VSW_BIT_ENABLE];
         fast_source_select_o <= next_fast_sel;
         side_path_enable_o   <= cfg[1][`VSW_BIT_ENABLE];
         side_source_select_o <= next_side_sel;
      end
   end

   // analog settings and termination
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         input_term_bits_o      <= 8'h00;
         eq_level_bits_o        <= 8'h00;
         emphasis_level_o       <= 2'h0;
         output_term_on_o       <= 1'b0;
         output_current_level_o <= 1'b0;
      end
      else
      begin
         input_term_bits_o      <= cfg[2][`VSW_BIT_TERM_MODE] ? 8'hff : cfg[3];
         eq_level_bits_o        <= cfg[4];
         emphasis_level_o       <= cfg[5][`VSW_MSB_EMPH:`VSW_LSB_EMPH];
         output_term_on_o       <= cfg[5][`VSW_BIT_OUT_TERM];
         output_current_level_o <= cfg[5][`VSW_BIT_OUT_CUR];
      end
   end

   vsw_byte_t act_map;

   // selected source's map drives the lane picks
   assign act_map = next_fast_sel ? cfg[8] : cfg[7];

   // lane polarity and routing
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         src_a_polarity_o  <= 4'h0;
         src_b_polarity_o  <= 4'h0;
         src_a_lane_map_o  <= 8'h00;
         src_b_lane_map_o  <= 8'h00;
         out_lane_pick_0_o <= 4'h0;
         out_lane_pick_1_o <= 4'h0;
         out_lane_pick_2_o <= 4'h0;
         out_lane_pick_3_o <= 4'h0;
      end
      else
      begin
         src_a_polarity_o  <= cfg[6][3:0];
         src_b_polarity_o  <= cfg[6][7:4];
         src_a_lane_map_o  <= cfg[7];
         src_b_lane_map_o  <= cfg[8];
         out_lane_pick_0_o <= lane_pick(act_map[1:0]);
         out_lane_pick_1_o <= lane_pick(act_map[3:2]);
         out_lane_pick_2_o <= lane_pick(act_map[5:4]);
         out_lane_pick_3_o <= lane_pick(act_map[7:6]);
      end
   end

   // ************************************************************
   // hot plug pulse on channel switch
   // ************************************************************

   vsw_hpd_if hpd_c ();
   logic      switch_evt;

   // either selection changing is a switch; reset never fires one
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
         switch_evt <= 1'b0;
      else
         switch_evt <= (next_fast_sel != fast_source_select_o)
                     | (next_side_sel != side_source_select_o);
   end

   assign hpd_c.switch_evt = switch_evt;

   vsw_hpd_timer #(
      .LOW_CYCLES (HPD_LOW_CYCLES)
   ) u_hpd (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .hpd     (hpd_c.tmr)
   );

   // open drain: pulled low or released
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         hot_plug_line_o    <= 1'b0;
         hot_plug_line_oe_o <= 1'b0;
         sda_o              <= 1'b0;
      end
      else
      begin
         hot_plug_line_o    <= 1'b0;
         hot_plug_line_oe_o <= hpd_c.hold_low;
         sda_o              <= 1'b0;
      end
   end
endmodule : vsw_regs_top

// >>> verification/vsw_bus_master.sv
// two-wire bus master: drives scl, pulls sda low
// assumes the bench resolves sda with a pull-up
module vsw_bus_master (
   // clock
   input  wire logic clk_i,
   // bus lines
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ***
   // bus phases
   // ***
   // bus idles released, scl high
   initial scl_o = 1'b1;
   initial sda_low_o = 1'b0;
   task automatic gap(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : gap
   // (repeated) start: sda falls, scl high
   task automatic start();
      sda_low_o = 1'b0;
      gap(5);
      scl_o = 1'b1;
      gap(20);
      sda_low_o = 1'b1;
      gap(20);
      scl_o = 1'b0;
      gap(15);
   endtask : start
   // stop: sda rises, scl high
   task automatic stop();
      sda_low_o = 1'b1;
      gap(5);
      scl_o = 1'b1;
      gap(20);
      sda_low_o = 1'b0;
      gap(20);
   endtask : stop
   // data moves while scl is low
   task automatic bit_io(input logic b, output logic s);
      sda_low_o = !b;
      gap(5);
      scl_o = 1'b1;
      gap(20);
      s = sda_i;
      scl_o = 1'b0;
      gap(15);
   endtask : bit_io
   // byte msb first, then ninth bit; reads send 8'hff
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(m, k);
   endtask : xfer
endmodule : vsw_bus_master

// >>> verification/vsw_regs_checker.sv
// port assertions for the switch block
// bound to vsw_regs_top, sees only its ports
module vsw_regs_checker
   import vsw_pkg::*;
#(
   parameter int unsigned HPD_LOW_CYCLES = 50
)(
   // clock and reset
   input wire logic      clk_i,
   input wire logic      rst_b_i,
   // bus and hot plug pins
   input wire logic      scl_i,
   input wire logic      sda_o,
   input wire logic      sda_oe_o,
   input wire logic      hot_plug_line_o,
   input wire logic      hot_plug_line_oe_o,
   // routing
   input wire logic      fast_source_select_o,
   input wire logic      side_source_select_o,
   input wire logic [3:0] out_lane_pick_0_o,
   input wire logic [3:0] out_lane_pick_3_o,
   input wire vsw_byte_t src_a_lane_map_o,
   input wire vsw_byte_t src_b_lane_map_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0]  run_q;
   int unsigned low_cnt;
   // outputs load defaults an edge after release; skip it
   always_ff @(posedge clk_i) run_q <= {run_q[0], rst_b_i};
   // hot plug low length
   always_ff @(posedge clk_i) low_cnt <= (!rst_b_i || !hot_plug_line_oe_o) ? 0 : low_cnt + 1;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // ***
   // properties
   // ***
   property p_hpd_len;
      $fell(hot_plug_line_oe_o) |-> low_cnt inside {[HPD_LOW_CYCLES - 1 : HPD_LOW_CYCLES + 1]};
   endproperty
   a_hpd_len: assert property (p_hpd_len) else $error("hot plug length");
   property p_hpd_fast;
      $changed(fast_source_select_o) |-> ##[0:3] hot_plug_line_oe_o;
   endproperty
   a_hpd_fast: assert property (p_hpd_fast) else $error("fast switch no pulse");
   property p_hpd_side;
      $changed(side_source_select_o) |-> ##[0:3] hot_plug_line_oe_o;
   endproperty
   a_hpd_side: assert property (p_hpd_side) else $error("side switch no pulse");
   property p_pins_low;
      hot_plug_line_o == 1'b0 && sda_o == 1'b0;
   endproperty
   a_pins_low: assert property (p_pins_low) else $error("pin driven high");
   property p_sda_timing;
      $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_sda_timing: assert property (p_sda_timing) else $error("sda moved, scl high");
   property p_ack_hold;
      $rose(sda_oe_o) |-> sda_oe_o [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
   property p_map_a;
      run_q[1] && !fast_source_select_o |-> out_lane_pick_0_o == 4'h1 << src_a_lane_map_o[1:0]
         && out_lane_pick_3_o == 4'h1 << src_a_lane_map_o[7:6];
   endproperty
   a_map_a: assert property (p_map_a) else $error("pick a");
   property p_map_b;
      run_q[1] && fast_source_select_o |-> out_lane_pick_0_o == 4'h1 << src_b_lane_map_o[1:0]
         && out_lane_pick_3_o == 4'h1 << src_b_lane_map_o[7:6];
   endproperty
   a_map_b: assert property (p_map_b) else $error("pick b");
   c_hpd: cover property ($rose(hot_plug_line_oe_o));
   c_fast: cover property ($rose(fast_source_select_o));
   c_drive: cover property ($rose(sda_oe_o));
endmodule : vsw_regs_checker
bind vsw_regs_top vsw_regs_checker #(.HPD_LOW_CYCLES(HPD_LOW_CYCLES)) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .hot_plug_line_o(hot_plug_line_o),
   .hot_plug_line_oe_o(hot_plug_line_oe_o), .fast_source_select_o(fast_source_select_o),
   .side_source_select_o(side_source_select_o), .out_lane_pick_0_o(out_lane_pick_0_o),
   .out_lane_pick_3_o(out_lane_pick_3_o), .src_a_lane_map_o(src_a_lane_map_o), .src_b_lane_map_o(src_b_lane_map_o));

// >>> verification/tb.sv
// self-checking bench for the switch block
// assumes model and checker are compiled first
`include "vsw_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] OFS [9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h14, 8'h20, 8'h80, 8'h81, 8'h82};
   localparam logic [7:0] RST [9] = '{8'h40, 8'hc0, 8'h01, 8'h00, 8'hff, 8'h03, 8'h00, 8'he4, 8'he4};
   localparam logic [7:0] WD  [9] = '{8'h01, 8'h01, 8'h00, 8'ha5, 8'h3c, 8'h09, 8'h96, 8'h1b, 8'h4e};
   logic       clk_i = 1'b0;
   logic       rst_b_i = 1'b0;
   logic       sel = 1'b0;
   logic       scl, sda_low, sda_oe, fpe, fss, spe, sss, ot, oc, hp_oe, hp_q;
   logic [1:0] emph;
   logic [3:0] p0, p1, p2, p3, pa, pb;
   logic [7:0] it, eq, ma, mb;
   int         bad_count = 0;
   int         checks_done = 0;
   int         cyc = 0;
   int         rises = 0;
   wire logic  sda = !(sda_low || sda_oe); // pulled up
   vsw_regs_top #(.HPD_LOW_CYCLES(50)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
      .sda_o(), .sda_oe_o(sda_oe), .addr_sel_i(sel), .hot_plug_line_o(), .hot_plug_line_oe_o(hp_oe),
      .fast_path_enable_o(fpe), .fast_source_select_o(fss), .out_lane_pick_0_o(p0), .out_lane_pick_1_o(p1),
      .out_lane_pick_2_o(p2), .out_lane_pick_3_o(p3), .src_a_polarity_o(pa), .src_b_polarity_o(pb),
      .side_path_enable_o(spe), .side_source_select_o(sss), .input_term_bits_o(it), .eq_level_bits_o(eq),
      .emphasis_level_o(emph), .output_term_on_o(ot), .output_current_level_o(oc), .src_a_lane_map_o(ma),
      .src_b_lane_map_o(mb));
   vsw_bus_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
   // ***
   // clock, ceiling and pulse count
   // ***
   always #50 clk_i = ~clk_i;
   // ceiling well above the ~55000 cycles needed
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      hp_q <= hp_oe;
      if (hp_oe === 1'b1 && hp_q === 1'b0) rises <= rises + 1;
      if (cyc == 80000)
      begin
         bad_count = bad_count + 1;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // write a register; k: expected ninth bits, 0 = ack
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic l, input logic [2:0] k);
      logic [7:0] q;
      logic [2:0] s;
      m.start();
      m.xfer({`VSW_DEV_ADDR_HI, l, 1'b0}, 1'b1, q, s[2]);
      m.xfer(a, 1'b1, q, s[1]);
      m.xfer(d, 1'b1, q, s[0]);
      m.stop();
      chk("write acks", {5'h0, k}, {5'h0, s});
   endtask : wr
   // set the pointer, read behind a repeated start
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      logic [1:0] s;
      m.start();
      m.xfer({`VSW_DEV_ADDR_HI, sel, 1'b0}, 1'b1, q, s[1]);
      m.xfer(a, 1'b1, q, s[0]);
      chk("read acks", 8'h00, {6'h0, s});
      rr(e);
   endtask : rd
   // reread the pointer, answered with no-ack
   task automatic rr(input logic [7:0] e);
      logic [7:0] q;
      logic       s;
      m.start();
      m.xfer({`VSW_DEV_ADDR_HI, sel, 1'b1}, 1'b1, q, s);
      m.xfer(8'hff, 1'b1, q, s);
      m.stop();
      chk("read data", e, q);
   endtask : rr
   // ***
   // tests
   // ***
   initial
   begin
      repeat (2) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      chk("modes", 8'ha3, {fpe, fss, spe, sss, emph, ot, oc});
      chk("terms", 8'hff, it);
      for (int i = 0; i < 9; i++) rd(OFS[i], RST[i]);
      $display("test defaults done");
      for (int i = 0; i < 9; i++) wr(OFS[i], WD[i], sel, 3'h0);
      for (int i = 0; i < 9; i++) rd(OFS[i], WD[i]);
      chk("modes", 8'h59, {fpe, fss, spe, sss, emph, ot, oc});
      chk("terms", 8'ha5, it);
      chk("eq", 8'h3c, eq);
      chk("signs", 8'h96, {pb, pa});
      chk("picks", 8'h48, {p0, p1});
      chk("picks", 8'h12, {p2, p3});
      rr(8'h4e);
      $display("test writes done");
      wr(8'h81, 8'h39, sel, 3'h0);
      wr(8'h00, 8'h40, sel, 3'h0);
      chk("picks", 8'h24, {p0, p1});
      chk("picks", 8'h81, {p2, p3});
      wr(8'h01, 8'h80, sel, 3'h0);
      chk("side", 8'h00, {7'h0, sss});
      wr(8'h00, 8'h41, sel, 3'h0);
      chk("side", 8'h01, {7'h0, sss});
      wr(8'h10, 8'h01, sel, 3'h0);
      chk("terms", 8'hff, it);
      chk("hot plug", 8'h04, rises[7:0]);
      $display("test modes done");
      wr(8'h55, 8'h77, sel, 3'h0);
      rd(8'h55, 8'h00);
      sel = 1'b1;
      wr(8'h14, 8'h00, 1'b0, 3'h7);
      rd(8'h14, 8'h3c);
      $display("test address done");
      rst_b_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      rd(8'h00, 8'h40);
      $display("test reset done");
      stop_test();
   end
endmodule : tb
